// ### rpsf_map.svh
`ifndef RPSF_MAP_SVH
`define RPSF_MAP_SVH

// register offsets seen by the local serial target
`define RPSF_PSEL_ADDR      8'h4C
`define RPSF_STS1_ADDR      8'h4D

// receive_port_status_one field positions
`define RPSF_PORT_NUM_HI    7
`define RPSF_PORT_NUM_LO    6
`define RPSF_CRC_BIT        5
`define RPSF_LOCK_CHG_BIT   4
`define RPSF_CHAN_BIT       3
`define RPSF_PARITY_BIT     2
`define RPSF_PASS_BIT       1
`define RPSF_LOCK_BIT       0

// port_select_register field positions
`define RPSF_RD_PORT_HI     5
`define RPSF_RD_PORT_LO     4
`define RPSF_WR_EN_HI       3
`define RPSF_WR_EN_LO       0

// reset values
`define RPSF_STS1_RESET     8'h00
`define RPSF_PSEL_RESET     8'h00
`define RPSF_UNMAPPED_DATA  8'h00

`endif

// ### rpsf_pkg.sv
package rpsf_pkg;

  // low six bits of receive_port_status_one for one port
  typedef logic [5:0] rpsf_flags_t;

  // receive port number as carried by the read-port field
  typedef logic [1:0] rpsf_port_t;

  // byte as moved over the register port
  typedef logic [7:0] rpsf_byte_t;

endpackage

// ### rpsf_port_flags.sv
`timescale 1ns/100ps
`include "rpsf_map.svh"

module rpsf_port_flags #(
  parameter int CNT_W = 16
) (
  input  wire logic               clock,
  input  wire logic               nrst,
  input  wire logic               crcFault,
  input  wire logic               seqFault,
  input  wire logic               anyFault,
  input  wire logic               enhancedEnable,
  input  wire logic               statusRead,
  input  wire logic               detailRead,
  input  wire logic               receiverLocked,
  input  wire logic               passMet,
  input  wire logic [CNT_W-1:0]   parityCount,
  input  wire logic [CNT_W-1:0]   parityThreshold,
  input  wire logic               parityCountClear,
  output rpsf_pkg::rpsf_flags_t   flags
);
  import rpsf_pkg::*;

  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
    $error("CNT_W must be 1 to 32");
  end

  rpsf_flags_t flags_reg;
  rpsf_flags_t flags_next;
  logic        chanSet;
  logic        chanClr;

  always_comb begin
    flags_next = flags_reg;
    // event wins over a read in the same cycle so nothing is lost
    // crc fault sticky
    flags_next[`RPSF_CRC_BIT] = crcFault |
      (flags_reg[`RPSF_CRC_BIT] & ~statusRead);
    flags_next[`RPSF_LOCK_CHG_BIT] =
      (receiverLocked != flags_reg[`RPSF_LOCK_BIT]) |
      (flags_reg[`RPSF_LOCK_CHG_BIT] & ~statusRead);
    // enhanced mode widens the source and moves the clear elsewhere
    // channel fault source
    chanSet = enhancedEnable ? anyFault : seqFault;
    chanClr = enhancedEnable ? detailRead : statusRead;
    flags_next[`RPSF_CHAN_BIT] = chanSet |
      (flags_reg[`RPSF_CHAN_BIT] & ~chanClr);
    // sticky until the counters are cleared, never by a status read
    // parity over threshold
    flags_next[`RPSF_PARITY_BIT] = (parityCount > parityThreshold) |
      (flags_reg[`RPSF_PARITY_BIT] & ~parityCountClear);
    flags_next[`RPSF_PASS_BIT] = passMet;
    flags_next[`RPSF_LOCK_BIT] = receiverLocked;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule

// ### rpsf_status_bank.sv
`timescale 1ns/100ps
`include "rpsf_map.svh"

// How it works
// - status register sits at 0x4D, every field zero after reset.
// - one copy per receive port; port select picks which copy is read.
// - bits 7:6 read back the currently selected read port number.
// - bit 5 sets on control channel CRC fault, clears on read.
// - bit 4 sets on any lock state change since last read, clears on read.
// - enhanced off: bit 3 flags sequence fault, clears on status read.
// - enhanced on: bit 3 flags any fault, clears on detail read only.
// - bit 2 sets once parity count exceeds the programmed threshold.
// - parity flag ignores status reads, clears when counters are cleared.
// - bit 1 shows live whether the input meets the pass criteria.
// - bit 0 reads one while the receiver is locked.
module rpsf_status_bank #(
  parameter int PORTS = 4,
  parameter int CNT_W = 16
) (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic [7:0]             regAddr,
  input  wire logic                   regRead,
  input  wire logic                   regWrite,
  input  wire logic [7:0]             regWdata,
  output rpsf_pkg::rpsf_byte_t        regRdata,
  output logic                        regRvalid,
  output rpsf_pkg::rpsf_port_t        readPort,
  output logic [3:0]                  writePortEnable,
  input  wire logic [PORTS-1:0]       crcFault,
  input  wire logic [PORTS-1:0]       seqFault,
  input  wire logic [PORTS-1:0]       anyFault,
  input  wire logic [PORTS-1:0]       enhancedEnable,
  input  wire logic [PORTS-1:0]       detailRead,
  input  wire logic [PORTS-1:0]       receiverLocked,
  input  wire logic [PORTS-1:0]       passMet,
  input  wire logic [PORTS*CNT_W-1:0] parityCount,
  input  wire logic [PORTS*CNT_W-1:0] parityThreshold,
  input  wire logic [PORTS-1:0]       parityCountClear
);
  import rpsf_pkg::*;

  if (PORTS < 1 || PORTS > 4) begin : g_bad_ports
    $error("PORTS must be 1 to 4, the read-port field is two bits");
  end
  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
    $error("CNT_W must be 1 to 32");
  end

  rpsf_port_t  readPort_reg;
  rpsf_port_t  readPort_next;
  logic [3:0]  wrEn_reg;
  logic [3:0]  wrEn_next;
  rpsf_byte_t  rdata_reg;
  rpsf_byte_t  rdata_next;
  logic        rvalid_reg;
  logic        rvalid_next;
  logic        stsRead;
  logic        pselWrite;
  logic [PORTS-1:0] stsReadPort;
  rpsf_flags_t portFlags [PORTS];

  function automatic logic addrHit(input logic [7:0] a,
                                   input logic [7:0] ref_a);
    addrHit = (a == ref_a);
  endfunction

  assign stsRead   = regRead & addrHit(regAddr, `RPSF_STS1_ADDR);
  assign pselWrite = regWrite & addrHit(regAddr, `RPSF_PSEL_ADDR);

  // clear-on-read reaches only the copy that the read returned
  always_comb begin
    stsReadPort = '0;
    for (int p = 0; p < PORTS; p++) begin
      stsReadPort[p] = stsRead && (int'(readPort_reg) == p);
    end
  end

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    rpsf_port_flags #(
      .CNT_W (CNT_W)
    ) u_flags (
      .clock            (clock),
      .nrst             (nrst),
      .crcFault         (crcFault[p]),
      .seqFault         (seqFault[p]),
      .anyFault         (anyFault[p]),
      .enhancedEnable   (enhancedEnable[p]),
      .statusRead       (stsReadPort[p]),
      .detailRead       (detailRead[p]),
      .receiverLocked   (receiverLocked[p]),
      .passMet          (passMet[p]),
      .parityCount      (parityCount[p*CNT_W +: CNT_W]),
      .parityThreshold  (parityThreshold[p*CNT_W +: CNT_W]),
      .parityCountClear (parityCountClear[p]),
      .flags            (portFlags[p])
    );
  end

  always_comb begin
    readPort_next = readPort_reg;
    wrEn_next     = wrEn_reg;
    rdata_next    = rdata_reg;
    rvalid_next   = regRead;
    if (pselWrite) begin
      readPort_next = regWdata[`RPSF_RD_PORT_HI:`RPSF_RD_PORT_LO];
      wrEn_next     = regWdata[`RPSF_WR_EN_HI:`RPSF_WR_EN_LO];
    end
    if (regRead) begin
      rdata_next = `RPSF_UNMAPPED_DATA;
      if (addrHit(regAddr, `RPSF_PSEL_ADDR)) begin
        // the physical port field reads zero over the local target
        rdata_next = {2'b00, readPort_reg, wrEn_reg};
      end else if (stsRead) begin
        rdata_next[`RPSF_PORT_NUM_HI:`RPSF_PORT_NUM_LO] = readPort_reg;
        // a non-existent port reads zero flags
        if (int'(readPort_reg) < PORTS) begin
          rdata_next[5:0] = portFlags[readPort_reg];
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      readPort_reg <= '0;
      wrEn_reg     <= '0;
      rdata_reg    <= `RPSF_STS1_RESET;
      rvalid_reg   <= 1'b0;
    end else begin
      readPort_reg <= readPort_next;
      wrEn_reg     <= wrEn_next;
      rdata_reg    <= rdata_next;
      rvalid_reg   <= rvalid_next;
    end
  end

  assign regRdata        = rdata_reg;
  assign regRvalid       = rvalid_reg;
  assign readPort        = readPort_reg;
  assign writePortEnable = wrEn_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  reset_zero_a: assert property (
    $rose(nrst) |-> regRdata == `RPSF_STS1_RESET && portFlags[0] == '0)
    else $error("status not zero after reset");

  port_num_a: assert property (
    stsRead |=> regRvalid &&
      regRdata[`RPSF_PORT_NUM_HI:`RPSF_PORT_NUM_LO] == $past(readPort_reg))
    else $error("port number field wrong");

  copy_sel_a: assert property (
    stsRead && int'(readPort_reg) < PORTS
      |=> regRdata[5:0] == $past(portFlags[readPort_reg]))
    else $error("read returned wrong port copy");

  sel_write_a: assert property (
    pselWrite |=> readPort == $past(regWdata[5:4]))
    else $error("read port select not taken");

  for (genvar p = 0; p < PORTS; p++) begin : g_chk
    crc_set_a: assert property (
      crcFault[p] |=> portFlags[p][`RPSF_CRC_BIT])
      else $error("crc fault not flagged");

    crc_clear_a: assert property (
      stsReadPort[p] ##0 !crcFault[p] |=> !portFlags[p][`RPSF_CRC_BIT])
      else $error("crc flag not cleared on read");

    lock_chg_a: assert property (
      receiverLocked[p] != portFlags[p][`RPSF_LOCK_BIT]
        |=> portFlags[p][`RPSF_LOCK_CHG_BIT] [*1] ##0
            portFlags[p][`RPSF_LOCK_BIT] == $past(receiverLocked[p]))
      else $error("lock change not flagged");

    seq_mode_a: assert property (
      !enhancedEnable[p] && stsReadPort[p] && !seqFault[p]
        |=> !portFlags[p][`RPSF_CHAN_BIT])
      else $error("sequence flag not cleared on read");

    enh_hold_a: assert property (
      enhancedEnable[p] && portFlags[p][`RPSF_CHAN_BIT] && !detailRead[p]
        |=> portFlags[p][`RPSF_CHAN_BIT])
      else $error("enhanced flag lost without detail read");

    enh_set_a: assert property (
      enhancedEnable[p] && anyFault[p] |=> portFlags[p][`RPSF_CHAN_BIT])
      else $error("enhanced fault not flagged");

    parity_set_a: assert property (
      parityCount[p*CNT_W +: CNT_W] > parityThreshold[p*CNT_W +: CNT_W]
        |=> portFlags[p][`RPSF_PARITY_BIT])
      else $error("parity over threshold not flagged");

    parity_hold_a: assert property (
      portFlags[p][`RPSF_PARITY_BIT] && !parityCountClear[p]
        |=> portFlags[p][`RPSF_PARITY_BIT])
      else $error("parity flag dropped early");

    pass_live_a: assert property (
      ##1 portFlags[p][`RPSF_PASS_BIT] == $past(passMet[p]))
      else $error("pass bit not tracking");

    lock_live_a: assert property (
      ##1 portFlags[p][`RPSF_LOCK_BIT] == $past(receiverLocked[p]))
      else $error("lock bit not tracking");
  end

  read_event_c: cover property (
    stsReadPort[0] && crcFault[0] ##1 portFlags[0][`RPSF_CRC_BIT]);
  enh_clear_c: cover property (
    enhancedEnable[0] && portFlags[0][`RPSF_CHAN_BIT] && detailRead[0]);
  lock_read_c: cover property (
    portFlags[0][`RPSF_LOCK_CHG_BIT] && stsReadPort[0]);
  port_three_c: cover property (
    stsRead && readPort_reg == 2'h3);

endmodule

// ### rpsf_host.sv
`timescale 1ns/100ps

module rpsf_host (
  input  wire logic           clock,
  output rpsf_pkg::rpsf_byte_t regAddr,
  output logic                regRead,
  output logic                regWrite,
  output rpsf_pkg::rpsf_byte_t regWdata,
  input  wire logic [7:0]     regRdata,
  input  wire logic           regRvalid
);
  import rpsf_pkg::*;

  initial begin
    regAddr = 8'h00;
    regRead = 1'b0;
    regWrite = 1'b0;
    regWdata = 8'h00;
  end

  task wr(input rpsf_byte_t a, input rpsf_byte_t d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    // released lines inverted so a stale value is never mistaken for valid
    regAddr <= ~a;
    regWdata <= ~d;
  endtask

  task rd(input rpsf_byte_t a, output rpsf_byte_t d);
    d = 8'hXX;
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    regAddr <= ~a;
    // bounded wait: a missing answer leaves unknown data behind
    for (int i = 0; i < 4; i++) begin
      @(negedge clock);
      if (regRvalid === 1'b1) begin
        d = regRdata;
        break;
      end
    end
  endtask
endmodule

// ### rpsf_status_bank_tb.sv
`timescale 1ns/100ps
`include "rpsf_map.svh"

module rpsf_status_bank_tb;
  import rpsf_pkg::*;

  logic            clock = 1'b0;
  logic            nrst = 1'b0;
  rpsf_byte_t      regAddr;
  rpsf_byte_t      regWdata;
  rpsf_byte_t      regRdata;
  logic            regRead;
  logic            regWrite;
  logic            regRvalid;
  rpsf_port_t      readPort;
  logic [3:0]      writePortEnable;
  logic [4:0][3:0] ev = '0;
  logic [3:0]      enhancedEnable = 4'h0;
  logic [3:0]      receiverLocked = 4'h0;
  logic [3:0]      passMet = 4'h0;
  logic [63:0]     parityCount = 64'h0;
  logic [63:0]     parityThreshold = {4{16'h0005}};
  int              failures = 0;
  int              checked = 0;
  int              cycles = 0;
  logic [15:0]     rows [8] = '{16'h0013, 16'h0003, 16'h1042, 16'h1042,
                                16'h2091, 16'h2081, 16'h30C0, 16'h30C0};

  rpsf_status_bank #(.PORTS(4), .CNT_W(16)) i_rpsf_status_bank (
    .clock(clock), .nrst(nrst), .regAddr(regAddr), .regRead(regRead),
    .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
    .regRvalid(regRvalid), .readPort(readPort),
    .writePortEnable(writePortEnable), .crcFault(ev[0]),
    .seqFault(ev[1]), .anyFault(ev[2]), .enhancedEnable(enhancedEnable),
    .detailRead(ev[3]), .receiverLocked(receiverLocked),
    .passMet(passMet), .parityCount(parityCount),
    .parityThreshold(parityThreshold), .parityCountClear(ev[4]));

  rpsf_host i_rpsf_host (
    .clock(clock), .regAddr(regAddr), .regRead(regRead),
    .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
    .regRvalid(regRvalid));

  always #2 clock = ~clock;

  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 1000) begin
      failures++;
      report_and_stop();
    end
  end

  task chk(input string n, input rpsf_byte_t e, input rpsf_byte_t g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task rdc(input rpsf_byte_t a, input rpsf_byte_t e);
    rpsf_byte_t d;
    i_rpsf_host.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask

  // one-cycle event on port 3 only, so other copies must stay clean
  task pulse(input int k);
    @(posedge clock);
    ev[k] <= 4'h8;
    @(posedge clock);
    ev[k] <= 4'h0;
  endtask

  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    rdc(`RPSF_STS1_ADDR, 8'h00);
    rdc(`RPSF_PSEL_ADDR, 8'h00);
    @(negedge clock);
    chk("regRvalid", 8'h00, {7'h00, regRvalid});
    @(posedge clock);
    receiverLocked <= 4'h5;
    passMet <= 4'h3;
    foreach (rows[i]) begin
      if (i % 2 == 0) begin
        i_rpsf_host.wr(`RPSF_PSEL_ADDR, rows[i][15:8]);
      end
      rdc(`RPSF_STS1_ADDR, rows[i][7:0]);
      chk("readPort", {6'h00, rows[i][13:12]}, {6'h00, readPort});
    end
    i_rpsf_host.wr(`RPSF_PSEL_ADDR, 8'hFF);
    rdc(`RPSF_PSEL_ADDR, 8'h3F);
    chk("writePortEnable", 8'h0F, {4'h0, writePortEnable});
    i_rpsf_host.wr(`RPSF_STS1_ADDR, 8'hFF);
    rdc(`RPSF_STS1_ADDR, 8'hC0);
    rdc(8'h10, 8'h00);
    @(posedge clock);
    receiverLocked <= 4'hD;
    rdc(`RPSF_STS1_ADDR, 8'hD1);
    rdc(`RPSF_STS1_ADDR, 8'hC1);
    pulse(0);
    rdc(`RPSF_STS1_ADDR, 8'hE1);
    rdc(`RPSF_STS1_ADDR, 8'hC1);
    pulse(0);
    fork
      rdc(`RPSF_STS1_ADDR, 8'hE1);
      pulse(0);
    join
    rdc(`RPSF_STS1_ADDR, 8'hE1);
    rdc(`RPSF_STS1_ADDR, 8'hC1);
    pulse(1);
    pulse(3);
    rdc(`RPSF_STS1_ADDR, 8'hC9);
    rdc(`RPSF_STS1_ADDR, 8'hC1);
    @(posedge clock);
    enhancedEnable <= 4'h8;
    pulse(2);
    rdc(`RPSF_STS1_ADDR, 8'hC9);
    rdc(`RPSF_STS1_ADDR, 8'hC9);
    pulse(3);
    rdc(`RPSF_STS1_ADDR, 8'hC1);
    @(posedge clock);
    parityCount[63:48] <= 16'h0005;
    rdc(`RPSF_STS1_ADDR, 8'hC1);
    @(posedge clock);
    parityCount[63:48] <= 16'h0006;
    rdc(`RPSF_STS1_ADDR, 8'hC5);
    @(posedge clock);
    parityCount[63:48] <= 16'h0000;
    rdc(`RPSF_STS1_ADDR, 8'hC5);
    rdc(`RPSF_STS1_ADDR, 8'hC5);
    pulse(4);
    rdc(`RPSF_STS1_ADDR, 8'hC1);
    report_and_stop();
  end
endmodule
